// *** drb_defs.svh ***
// Purpose: Constants for the read burst control block
// Assumes: System clock of 40 MHz; 8-bit data lane, 8 banks
// Notes: Times are in picoseconds, cycle counts derived from them
//
// Summary of operation
// RULE1 - First read element appears additive plus CAS latency clocks after READ. Latency below two is served as two.
// RULE2 - Later elements follow on every rising and falling link clock edge.
// RULE3 - Strobe driven with data; strobe low, complement high as preamble first.
// RULE4 - Strobe low, complement high during the final element as postamble.
// RULE5 - Data lines go high impedance once a burst ends with nothing pending.
// RULE6 - READ after half burst length clocks continues data without any gap.
// RULE7 - Controller never interrupts a burst of length four.
// RULE8 - Length eight burst cut only by another READ on four-element boundary.
// RULE9 - Interrupting READ comes exactly two clocks after the one interrupted.
// RULE10 - Interrupting READ may use auto precharge; its banks are not precharged. Here its bank is precharged as after any auto precharge READ.
// RULE11 - Spacing after auto precharge READ to other banks follows fixed clocks.
// RULE12 - Read data completes before any following write burst starts.
// RULE13 - Same-bank PRECHARGE waits additive latency plus half burst, and read-to-precharge.
// RULE14 - Read-to-precharge measured from internal READ, or two clocks later for eight.
// RULE15 - After PRECHARGE, no bank command until row precharge time elapses.
// RULE16 - Auto precharge select bit high on READ closes the row after burst.
// RULE17 - Auto precharge starts additive plus half burst later, held for row times.
// RULE18 - Row precharge interval counts from the actual internal precharge moment.
// RULE19 - Next ACTIVATE after auto precharge read waits summed rounded-up times.
// RULE20 - Internal precharge never before two clocks after the final prefetch.
// RULE21 - Explicit PRECHARGE only after minimum row active time is met.
// RULE22 - Controller rounds every minimum time up to whole clocks.
// RULE23 - READ only to an open row after activate-to-read delay less additive latency.
// RULE24 - Controller tracks per-bank timers and data bus occupancy.
// RULE25 - Elements follow programmed burst order from the supplied start column.
`ifndef DRB_DEFS_SVH
`define DRB_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DRB_REG_CFG 8'h00
`define DRB_REG_TIM 8'h04
`define DRB_REG_STAT 8'h08
`define DRB_CFG_RST 32'h0000_0030
`define DRB_CFG_AL_LSB 0
`define DRB_CFG_CL_LSB 4
`define DRB_CFG_BL8_BIT 8
`define DRB_CFG_ILV_BIT 9
`define DRB_TIM_RAS_LSB 0
`define DRB_TIM_RTP_LSB 8
`define DRB_TIM_RP_LSB 16
`define DRB_STAT_OPEN_LSB 0
`define DRB_STAT_BUSY_LSB 8
`define DRB_STAT_ACT_BIT 16

// ----------------------------------------
// Timing
// ----------------------------------------
`define DRB_CLK_PS 25000
`define DRB_RAS_PS 40000
`define DRB_RTP_PS 7500
`define DRB_RP_PS 15000
`define DRB_CYC(ps) (((ps) + `DRB_CLK_PS - 1) / `DRB_CLK_PS)

// ----------------------------------------
// Burst geometry
// ----------------------------------------
`define DRB_AP_BIT 10
`define DRB_LEN4 4'h4
`define DRB_LEN8 4'h8
`define DRB_HALF4 4'h2
`define DRB_HALF8 4'h4
`define DRB_PREFETCH_LEAD 4'h2
`define DRB_SLOT_LEAD 4'h2
`define DRB_PIPE_DEPTH 16
`define DRB_NBANK 8

`endif

// *** drb_pkg.sv ***
// Purpose: Types shared by the read burst control block
// Assumes: Constants come from drb_defs.svh
// Notes: None
package drb_pkg;

  // Command and clock pins as seen on the ball side
  typedef struct packed {
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } drb_pins_t;

  // One scheduled read burst
  typedef struct packed {
    logic valid;
    logic bl8;
    logic [2:0] bank;
    logic [9:0] col;
  } drb_burst_t;

  typedef enum logic [1:0] {
    DRB_IDLE = 2'b00,
    DRB_PRE = 2'b01,
    DRB_DATA = 2'b10
  } drb_state_t;

endpackage

// *** drb_read_burst.sv ***
// Purpose: Device-side read burst engine with auto precharge timing
// Assumes: Link clock and command pins are asynchronous and sampled here
// Notes: Array read port is combinational on the system clock
`timescale 1ns/1ps
`include "drb_defs.svh"

module drb_read_burst (
  // System
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Command pins
  input wire drb_pkg::drb_pins_t cmd_pins,
  // Data pins, active-low output enables
  output logic [7:0] dq_o,
  output logic dq_oe_n,
  output logic dqs_o,
  output logic dqs_c_o,
  output logic dqs_oe_n,
  // Array read port
  output logic [2:0] arr_bank,
  output logic [9:0] arr_col,
  input wire logic [7:0] arr_rdata,
  // Bank status
  output logic [7:0] bank_open,
  output logic [7:0] precharge_start
);

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  drb_pkg::drb_pins_t pin_s1_r;
  drb_pkg::drb_pins_t pin_s2_r;
  logic ck_q_r;
  logic ck_rise;
  logic ck_fall;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ck_q_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= cmd_pins;
      pin_s2_r <= pin_s1_r;
      ck_q_r <= pin_s2_r.ck;
    end
  end

  assign ck_rise = pin_s2_r.ck & ~ck_q_r;
  assign ck_fall = ~pin_s2_r.ck & ck_q_r;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] cfg_r;
  logic [31:0] tim_r;
  logic [31:0] rdata_r;
  logic [31:0] stat_w;
  logic [2:0] al;
  logic [2:0] cl;
  logic bl8;
  logic ilv;
  logic [7:0] ras_cfg;
  logic [7:0] rtp_cfg;
  logic [7:0] rp_cfg;

  assign al = cfg_r[`DRB_CFG_AL_LSB +: 3];
  assign cl = cfg_r[`DRB_CFG_CL_LSB +: 3];
  assign bl8 = cfg_r[`DRB_CFG_BL8_BIT];
  assign ilv = cfg_r[`DRB_CFG_ILV_BIT];
  assign ras_cfg = tim_r[`DRB_TIM_RAS_LSB +: 8];
  assign rtp_cfg = tim_r[`DRB_TIM_RTP_LSB +: 8];
  assign rp_cfg = tim_r[`DRB_TIM_RP_LSB +: 8];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_r <= `DRB_CFG_RST;
      tim_r <= {8'h00, 8'(`DRB_CYC(`DRB_RP_PS)), 8'(`DRB_CYC(`DRB_RTP_PS)),
                8'(`DRB_CYC(`DRB_RAS_PS))};
    end
    else if (reg_wr)
    begin
      if (reg_addr == `DRB_REG_CFG)
        cfg_r <= {22'h00_0000, reg_wdata[9:8], 1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
      if (reg_addr == `DRB_REG_TIM)
        tim_r <= {8'h00, reg_wdata[23:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `DRB_REG_CFG: rdata_r <= cfg_r;
        `DRB_REG_TIM: rdata_r <= tim_r;
        `DRB_REG_STAT: rdata_r <= stat_w;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
    else
      rdata_r <= 32'h0000_0000;
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  drb_pkg::drb_pins_t cmd;
  logic sel;
  logic is_read;
  logic is_act;
  logic is_pre;
  logic ap_sel;
  logic [3:0] rl;
  logic [3:0] slot_idx;
  logic [3:0] half_bl;
  logic [3:0] ap_load;

  assign cmd = pin_s2_r;
  assign sel = ck_rise & ~cmd.cs_n;
  assign is_read = sel & cmd.ras_n & ~cmd.cas_n & cmd.we_n;
  assign is_act = sel & ~cmd.ras_n & cmd.cas_n & cmd.we_n;
  assign is_pre = sel & ~cmd.ras_n & cmd.cas_n & ~cmd.we_n;
  assign ap_sel = cmd.addr[`DRB_AP_BIT];
  assign rl = {1'b0, al} + {1'b0, cl}; // [RULE1]
  // Limitation: latency below two is served as two
  assign slot_idx = (rl < `DRB_SLOT_LEAD) ? 4'h0 : rl - `DRB_SLOT_LEAD;
  assign half_bl = bl8 ? `DRB_HALF8 : `DRB_HALF4;
  assign ap_load = {1'b0, al} + half_bl; // [RULE17]

  // ----------------------------------------
  // Latency pipe, one slot per link clock
  // ----------------------------------------
  drb_pkg::drb_burst_t pipe_r [`DRB_PIPE_DEPTH];
  drb_pkg::drb_burst_t head;
  drb_pkg::drb_burst_t new_burst;

  assign head = pipe_r[0];
  assign new_burst = '{valid: 1'b1, bl8: bl8, bank: cmd.ba, col: cmd.addr[9:0]};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < `DRB_PIPE_DEPTH; i++)
        pipe_r[i] <= '0;
    end
    else if (ck_rise)
    begin
      for (int i = 0; i < `DRB_PIPE_DEPTH - 1; i++)
        pipe_r[i] <= pipe_r[i + 1];
      pipe_r[`DRB_PIPE_DEPTH - 1] <= '0;
      // Engine sees the head one rise later, so the preamble lands at latency minus one
      if (is_read)
        pipe_r[slot_idx] <= new_burst; // [RULE1] [RULE3]
    end
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  drb_pkg::drb_state_t st_r;
  drb_pkg::drb_burst_t cur_r;
  drb_pkg::drb_burst_t next_r;
  logic [3:0] elem_r;
  logic [3:0] len;
  logic take_next;
  logic done_w;
  logic [7:0] dq_r;
  logic dq_drive_r;
  logic dqs_r;
  logic dqs_drive_r;

  function automatic logic [9:0] col_of(input logic [9:0] base, input logic [3:0] idx,
                                        input logic len8, input logic inter);
    logic [9:0] mask;
    logic [9:0] off;
    mask = len8 ? 10'h007 : 10'h003;
    off = inter ? (base ^ {6'h00, idx}) : (base + {6'h00, idx});
    return (base & ~mask) | (off & mask);
  endfunction

  assign len = cur_r.bl8 ? `DRB_LEN8 : `DRB_LEN4;
  // Truncation only at a four-element boundary
  assign take_next = (st_r == drb_pkg::DRB_DATA) && (elem_r[1:0] == 2'b00) &&
                     (elem_r != 4'h0) && next_r.valid; // [RULE6] [RULE8] [RULE10]
  assign done_w = (elem_r == len) && !take_next;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= drb_pkg::DRB_IDLE;
      cur_r <= '0;
      elem_r <= 4'h0;
      dq_r <= 8'h00;
      dq_drive_r <= 1'b0;
      dqs_r <= 1'b0;
      dqs_drive_r <= 1'b0;
    end
    else if (ck_rise)
    begin
      unique case (st_r)
        drb_pkg::DRB_IDLE:
        begin
          if (head.valid)
          begin
            st_r <= drb_pkg::DRB_PRE;
            cur_r <= head;
            elem_r <= 4'h0;
            dqs_r <= 1'b0; // [RULE3]
            dqs_drive_r <= 1'b1;
          end
        end
        drb_pkg::DRB_PRE:
        begin
          st_r <= drb_pkg::DRB_DATA;
          dq_r <= arr_rdata; // [RULE1]
          dq_drive_r <= 1'b1;
          dqs_r <= 1'b1; // [RULE3]
          elem_r <= 4'h1;
        end
        drb_pkg::DRB_DATA:
        begin
          if (take_next)
          begin
            cur_r <= next_r; // [RULE6] [RULE8]
            dq_r <= arr_rdata;
            dqs_r <= 1'b1;
            elem_r <= 4'h1;
          end
          else if (!done_w)
          begin
            dq_r <= arr_rdata; // [RULE2]
            dqs_r <= 1'b1;
            elem_r <= elem_r + 4'h1;
          end
          else if (head.valid)
          begin
            // Gap of one clock: strobe stays low as the new preamble
            st_r <= drb_pkg::DRB_PRE;
            cur_r <= head;
            elem_r <= 4'h0;
            dq_drive_r <= 1'b0;
            dqs_r <= 1'b0;
          end
          else
          begin
            st_r <= drb_pkg::DRB_IDLE;
            dq_drive_r <= 1'b0; // [RULE5]
            dqs_drive_r <= 1'b0;
            dqs_r <= 1'b0;
          end
        end
        default: st_r <= drb_pkg::DRB_IDLE;
      endcase
    end
    else if (ck_fall && st_r == drb_pkg::DRB_DATA && elem_r[0])
    begin
      dq_r <= arr_rdata; // [RULE2]
      dqs_r <= 1'b0; // [RULE4]
      elem_r <= elem_r + 4'h1;
    end
  end

  // Follow-on burst held until the current one reaches a boundary
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      next_r <= '0;
    else if (ck_rise)
    begin
      if (take_next)
        next_r.valid <= 1'b0;
      if (head.valid && st_r == drb_pkg::DRB_DATA && !done_w)
        next_r <= head; // [RULE6]
    end
  end

  // Address for the element due at the next edge
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arr_bank <= 3'h0;
      arr_col <= 10'h000;
    end
    else if ((st_r == drb_pkg::DRB_DATA) && (elem_r[1:0] == 2'b00) && next_r.valid)
    begin
      arr_bank <= next_r.bank;
      arr_col <= col_of(next_r.col, 4'h0, next_r.bl8, ilv); // [RULE25]
    end
    else
    begin
      arr_bank <= cur_r.bank;
      arr_col <= col_of(cur_r.col, elem_r, cur_r.bl8, ilv); // [RULE25]
    end
  end

  assign dq_o = dq_r;
  assign dq_oe_n = ~dq_drive_r;
  assign dqs_o = dqs_r;
  assign dqs_c_o = ~dqs_r; // [RULE3] [RULE4]
  assign dqs_oe_n = ~dqs_drive_r;

  // ----------------------------------------
  // Per-bank row timers and auto precharge
  // ----------------------------------------
  logic [7:0] open_r;
  logic [7:0] ap_pend_r;
  logic [7:0] rtp_run_r;
  logic [7:0] pc_start_r;
  logic [7:0] ras_cnt_r [`DRB_NBANK];
  logic [7:0] rtp_cnt_r [`DRB_NBANK];
  logic [7:0] rp_cnt_r [`DRB_NBANK];
  logic [3:0] ap_ck_r [`DRB_NBANK];
  logic [7:0] busy_w;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      open_r <= 8'h00;
      ap_pend_r <= 8'h00;
      rtp_run_r <= 8'h00;
      pc_start_r <= 8'h00;
      for (int b = 0; b < `DRB_NBANK; b++)
      begin
        ras_cnt_r[b] <= 8'h00;
        rtp_cnt_r[b] <= 8'h00;
        rp_cnt_r[b] <= 8'h00;
        ap_ck_r[b] <= 4'h0;
      end
    end
    else
    begin
      for (int b = 0; b < `DRB_NBANK; b++)
      begin
        logic hit;
        logic ap_new;
        logic rtp_go;
        logic fire;
        hit = (cmd.ba == 3'(b));
        ap_new = is_read && ap_sel && hit; // [RULE16]
        // Read-to-precharge window opens at the final prefetch
        rtp_go = (ap_new && ap_load == `DRB_PREFETCH_LEAD) ||
                 (ck_rise && ap_pend_r[b] && ap_ck_r[b] == `DRB_PREFETCH_LEAD + 4'h1);
        // May fall between link clock edges once the timers expire
        fire = ap_pend_r[b] && (ap_ck_r[b] == 4'h0) && rtp_run_r[b] &&
               (rtp_cnt_r[b] == 8'h00) && (ras_cnt_r[b] == 8'h00); // [RULE17] [RULE20]
        pc_start_r[b] <= fire;

        if (is_act && hit)
          ras_cnt_r[b] <= ras_cfg;
        else if (ras_cnt_r[b] != 8'h00)
          ras_cnt_r[b] <= ras_cnt_r[b] - 8'h01;

        if (ap_new)
          ap_ck_r[b] <= ap_load; // [RULE17]
        else if (ck_rise && ap_ck_r[b] != 4'h0)
          ap_ck_r[b] <= ap_ck_r[b] - 4'h1;

        if (rtp_go)
        begin
          rtp_run_r[b] <= 1'b1;
          rtp_cnt_r[b] <= rtp_cfg; // [RULE17]
        end
        else if (fire)
          rtp_run_r[b] <= 1'b0;
        else if (rtp_cnt_r[b] != 8'h00)
          rtp_cnt_r[b] <= rtp_cnt_r[b] - 8'h01;

        if (ap_new)
          ap_pend_r[b] <= 1'b1;
        else if (fire)
          ap_pend_r[b] <= 1'b0;

        if (fire || (is_pre && (hit || cmd.addr[`DRB_AP_BIT])))
          rp_cnt_r[b] <= rp_cfg; // [RULE18]
        else if (rp_cnt_r[b] != 8'h00)
          rp_cnt_r[b] <= rp_cnt_r[b] - 8'h01;

        if (is_act && hit)
          open_r[b] <= 1'b1;
        else if (fire || (is_pre && (hit || cmd.addr[`DRB_AP_BIT])))
          open_r[b] <= 1'b0; // [RULE16]
      end
    end
  end

  always_comb
  begin
    for (int b = 0; b < `DRB_NBANK; b++)
      busy_w[b] = (rp_cnt_r[b] != 8'h00) || ap_pend_r[b];
  end

  assign stat_w = {15'h0000, (st_r != drb_pkg::DRB_IDLE), busy_w, open_r};
  assign bank_open = open_r;
  assign precharge_start = pc_start_r;

endmodule

// *** drb_read_burst_chk.sv ***
// Purpose: Port assertions of the read burst engine
// Assumes: Link clock phase fixed to clk_sys
// Notes: Bound from the bench top
`timescale 1ns/1ps
module drb_read_burst_chk (
  // System
  input wire logic clk_sys,
  input wire logic arst_n,
  // Watched outputs and the register read strobe
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dq_oe_n,
  input wire logic dqs_o,
  input wire logic dqs_c_o,
  input wire logic dqs_oe_n,
  input wire logic [7:0] bank_open,
  input wire logic [7:0] precharge_start
);
  logic [7:0] pc_r;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pc_r <= 8'h00;
    else
      pc_r <= precharge_start;
  end
  a_strobe_pair: assert property (dqs_c_o == !dqs_o)
    else $error("strobe pair split");
  a_data_strobe: assert property (!dq_oe_n |-> !dqs_oe_n)
    else $error("data without strobe");
  // Preamble is one link clock, eight system clocks
  a_preamble_shape: assert property ($fell(dqs_oe_n) |->
    (dq_oe_n && !dqs_o) [*8] ##1 (!dq_oe_n && dqs_o))
    else $error("bad preamble");
  a_postamble_low: assert property ($rose(dq_oe_n) |-> !$past(dqs_o))
    else $error("bad postamble");
  a_release_order: assert property ($rose(dqs_oe_n) |-> dq_oe_n)
    else $error("strobe freed before data");
  a_element_hold: assert property (!dq_oe_n && $changed(dqs_o) |=> $stable(dqs_o) [*3])
    else $error("short element");
  a_burst_whole: assert property ($fell(dq_oe_n) |=> (!dq_oe_n) [*8] ##1 (!dq_oe_n) [*7])
    else $error("burst cut short");
  a_pulse_single: assert property (|precharge_start |=> (precharge_start & pc_r) == 8'h00)
    else $error("long precharge pulse");
  a_precharge_closes: assert property (|precharge_start |=> (bank_open & pc_r) == 8'h00)
    else $error("row left open");
  a_rdata_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stray read data");
endmodule

// *** drb_ctrl_model.sv ***
// Purpose: Memory controller model driving the command pins
// Assumes: Link clock free running, 200 ns period
// Notes: A command holds from one link fall to the next
`timescale 1ns/1ps
module drb_ctrl_model (
  // Pins
  output drb_pkg::drb_pins_t pins
);
  logic ck;
  logic [3:0] code;
  logic [2:0] ba;
  logic [13:0] a;
  assign pins = {ck, code, ba, a};
  initial
  begin
    ck = 1'b0;
    code = 4'h7;
    ba = 3'h0;
    a = 14'h0000;
    #7;
    forever #100 ck = ~ck;
  end
  // Set on the fall so the sync flops see a settled command
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] ad,
    output time t);
    @(negedge ck);
    code = c;
    ba = (c == 4'h7) ? ~ba : b;
    a = (c == 4'h7) ? ~a : ad;
    @(posedge ck);
    t = $time;
  endtask
  // Spacing in whole link clocks
  task automatic nop(input int n);
    time t;
    repeat (n) issue(4'h7, 3'h0, 14'h0000, t);
  endtask
endmodule

// *** drb_read_burst_tb.sv ***
// Purpose: Self-checking bench of the read burst engine
// Assumes: 40 MHz clk_sys, 200 ns link clock from the model
// Notes: Elements sampled 150 ns past their link edge
`timescale 1ns/1ps
`include "drb_defs.svh"
module drb_read_burst_tb;
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rnd = 32'h0001_8330;
  logic [7:0] dq_o, arr_rdata, bank_open, precharge_start;
  logic dq_oe_n, dqs_o, dqs_c_o, dqs_oe_n;
  logic [2:0] arr_bank;
  logic [9:0] arr_col;
  drb_pkg::drb_pins_t cmd_pins;
  int bad_count = 0;
  int tests_run = 0;
  always #12.5 clk_sys = ~clk_sys;
  drb_ctrl_model ctl (.pins(cmd_pins));
  drb_read_burst dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_pins(cmd_pins), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o),
    .dqs_oe_n(dqs_oe_n), .arr_bank(arr_bank), .arr_col(arr_col), .arr_rdata(arr_rdata),
    .bank_open(bank_open), .precharge_start(precharge_start));
  // Byte names its bank and column, so misordering shows
  function automatic logic [7:0] mem(input logic [2:0] b, input logic [9:0] c);
    return {c[4:0], b} ^ 8'hA5;
  endfunction
  assign arr_rdata = mem(arr_bank, arr_col);
  function automatic logic [9:0] ecol(input logic [9:0] s, input int i, input logic b8, il);
    logic [9:0] w;
    w = b8 ? 10'h007 : 10'h003;
    return (s & ~w) | ((il ? (s ^ 10'(i)) : (s + 10'(i))) & w);
  endfunction
  function automatic void draw();
    repeat (11) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic conclude();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, mk, input string n);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata & mk);
  endtask
  task automatic pair(input int al, cl, input logic b8, il, input int gap, input logic ap);
    int bl, n1, rl;
    logic [2:0] b1, b2;
    logic [9:0] s1, s2;
    logic [31:0] e, g;
    time t;
    bl = b8 ? 8 : 4;
    rl = al + cl;
    n1 = (2 * gap < bl) ? 2 * gap : bl;
    wr(`DRB_REG_CFG, {22'h0, il, b8, 1'b0, 3'(cl), 1'b0, 3'(al)});
    draw();
    b1 = rnd[2:0];
    b2 = b1 + 3'(rnd[4:3]) + 3'h1;
    s1 = rnd[14:5];
    s2 = rnd[24:15];
    ctl.issue(4'h3, b1, 14'h0000, t);
    ctl.issue(4'h3, b2, 14'h0000, t);
    ctl.nop(3);
    fork
      begin
        ctl.issue(4'h5, b1, {4'h0, s1}, t);
        ctl.nop(gap - 1);
        ctl.issue(4'h5, b2, {3'h0, ap, s2}, t);
        ctl.nop(bl + rl + 2);
      end
      begin
        @(negedge ctl.ck);
        @(posedge ctl.ck);
        #((rl - 1) * 200 + 150);
        chk("preamble", 32'h0000_0004, 32'({dq_oe_n, dqs_oe_n, dqs_o}));
        for (int i = 0; i < n1 + bl; i++)
        begin
          #(i == 0 ? 200 : 100);
          g = 32'({dq_oe_n, dqs_oe_n, dqs_o, dq_o});
          e = 32'({2'b00, !i[0], i < n1 ? mem(b1, ecol(s1, i, b8, il))
            : mem(b2, ecol(s2, i - n1, b8, il))});
          chk("element", e, g);
        end
        #100 chk("release", 32'h0000_0003, 32'({dq_oe_n, dqs_oe_n}));
      end
    join
    ctl.issue(4'h2, 3'h0, 14'h0400, t);
    ctl.nop(2);
    chk("bank_open", 32'h0000_0000, 32'(bank_open));
  endtask
  // Pulse window is wide enough for sync lag, not for a lost link clock
  task automatic ap_case(input int ras, rtp, al, input logic b8);
    int m, d, h;
    time ta, tr, tp;
    logic [2:0] b;
    h = b8 ? 4 : 2;
    wr(`DRB_REG_TIM, {8'h00, 8'h14, 8'(rtp), 8'(ras)});
    wr(`DRB_REG_CFG, {23'h0, b8, 1'b0, 3'h3, 1'b0, 3'(al)});
    draw();
    b = rnd[2:0];
    ctl.issue(4'h3, b, 14'h0000, ta);
    ctl.issue(4'h5, b, {4'h1, rnd[12:3]}, tr);
    ctl.nop(1);
    m = (al + h) * 200;
    d = (al + h - 2) * 200 + rtp * 25;
    m = d > m ? d : m;
    d = ras * 25 - int'(tr - ta);
    m = d > m ? d : m;
    tp = 0;
    for (int k = 0; k < 400 && tp == 0; k++)
    begin
      @(posedge clk_sys);
      #1 if (precharge_start[b] === 1'b1) tp = $time;
    end
    if (tp == 0)
    begin
      $display("ERROR precharge_start expected pulse seen none");
      bad_count++;
      conclude();
    end
    d = int'(tp - tr);
    chk("ap_delay", 32'h0000_0001, 32'(d >= m + 50 && d < m + 175));
    @(posedge clk_sys);
    #1 chk("ap_close", 32'h0000_0000, 32'(bank_open[b]));
    rd(`DRB_REG_STAT, 32'h0000_0100 << b, 32'h0000_FF00, "busy");
    repeat (19) @(posedge clk_sys);
    rd(`DRB_REG_STAT, 32'h0000_0000, 32'h0000_FF00, "idle");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`DRB_REG_CFG, 32'h0000_0030, 32'hFFFF_FFFF, "cfg_reset");
    rd(`DRB_REG_TIM, 32'h0001_0102, 32'hFFFF_FFFF, "tim_reset");
    rd(`DRB_REG_STAT, 32'h0000_0000, 32'hFFFF_FFFF, "stat_reset");
    wr(`DRB_REG_STAT, 32'hFFFF_FFFF);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    rd(`DRB_REG_STAT, 32'h0000_0000, 32'hFFFF_FFFF, "stat_ro");
    wr(`DRB_REG_CFG, 32'hFFFF_FFFF);
    rd(`DRB_REG_CFG, 32'h0000_0377, 32'hFFFF_FFFF, "cfg_bits");
    repeat (2)
    begin
      pair(0, 3, 1'b0, 1'b0, 2, 1'b0);
      pair(1, 4, 1'b1, 1'b1, 4, 1'b0);
      pair(0, 3, 1'b1, 1'b0, 2, 1'b1);
      pair(2, 5, 1'b0, 1'b1, 2, 1'b1);
    end
    ap_case(2, 1, 0, 1'b0);
    ap_case(2, 1, 1, 1'b1);
    ap_case(2, 60, 0, 1'b0);
    ap_case(120, 1, 0, 1'b1);
    conclude();
  end
endmodule
bind drb_read_burst drb_read_burst_chk chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o),
  .dqs_c_o(dqs_c_o), .dqs_oe_n(dqs_oe_n), .bank_open(bank_open),
  .precharge_start(precharge_start));
